// ---- adc_sequencing_control.sv ----
// sequencing, timing and register logic of an eight-input converter
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"
module adc_sequencing_control
    import adc_seq_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_RESULTS = 4
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic warm_reset_pin_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic conv_done_i,
    input wire logic [7:0] conv_data_i,
    output logic [2:0] mux_channel_o,
    output logic conv_start_o,
    output logic conv_abort_o,
    output logic conv_clk_tick_o,
    output logic int_ref_on_o,
    output logic irq_o
);
    if (ADDR_W < 5 || ADDR_W > 8 || NUM_RESULTS != 4)
    begin : g_bad_params
        $error("unsupported address width or result count");
    end

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off[ADDR_W-1:0]);
    endfunction

    // ratio 2**code; reserved codes clamp to the largest legal value
    function automatic logic [6:0] pow2(input logic [2:0] code, input logic [2:0] lim);
        pow2 = 7'h01 << ((code > lim) ? lim : code);
    endfunction

    // -------------------------------------------------------------
    // reset release and state
    // -------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;
    enable_s enable_reg, enable_next;
    mode_s mode_reg, mode_next;
    timing_s timing_reg;
    seq_state_e state_reg, state_next;
    logic eoc_reg, eoc_next, ovf_reg;
    logic [1:0] ptr_reg, burst_reg;
    logic [2:0] chan_reg;
    logic [3:0] full_reg;
    logic [4:0] div_cnt_reg;
    logic [6:0] smp_cnt_reg;
    logic [7:0] result_mem [4];
    logic conv_start_reg, abort_reg, tick_reg, ref_reg, irq_reg;
    logic [7:0] rdata_reg;

    // release is synchronised so no flop leaves reset on a split edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    wire wr_enable = wr_i && hit(addr_i, `ADC_OFF_ENABLE);
    wire wr_status = wr_i && hit(addr_i, `ADC_OFF_STATUS);
    wire wr_mode = wr_i && hit(addr_i, `ADC_OFF_MODE);
    wire wr_timing = wr_i && hit(addr_i, `ADC_OFF_TIMING);
    wire res_hit = (addr_i[ADDR_W-1:4] == `ADC_OFF_RESULT0 >> 4) && (addr_i[1:0] == 2'b00);
    wire [1:0] res_idx = addr_i[3:2];
    wire rd_res = rd_i && res_hit;
    wire wr_res = wr_i && res_hit && !enable_reg.converter_enable;

    // -------------------------------------------------------------
    // sequencing conditions
    // -------------------------------------------------------------
    wire warm = warm_reset_pin_i;
    wire busy = (state_reg != ST_IDLE);
    wire [6:0] ratio = pow2(timing_reg.conv_clock_divide, `ADC_CONV_CLOCK_DIVIDE_MAX);
    wire [6:0] delay_cyc = pow2(timing_reg.delay, `ADC_DELAY_MAX);
    wire tick = enable_reg.converter_enable && ({2'b00, div_cnt_reg} == ratio - 7'd1);
    wire done = (state_reg == ST_CONVERT) && conv_done_i;
    wire [1:0] wr_idx = ptr_reg + 2'd1;
    wire last_in_unit = !mode_reg.scan || (burst_reg == 2'd3);
    wire restart = done && last_in_unit && mode_reg.continuous_bit && mode_reg.start;
    wire stopping = done && last_in_unit && !restart;
    wire en_fall = enable_reg.converter_enable && !enable_next.converter_enable;
    wire start_rise = wr_mode && wdata_i[7] && !mode_reg.start
        && enable_reg.converter_enable && !busy;
    wire eoc_set = done && (wr_idx == 2'd3 || stopping);
    wire smp_go = (state_reg == ST_SAMPLE) && tick && (smp_cnt_reg == 7'd1);

    // enable register next value
    assign enable_next = warm ? enable_s'(`ADC_RST_ENABLE)
        : wr_enable ? enable_s'(wdata_i[2:0]) : enable_reg;

    // abort and warm reset outrank a same-cycle completion
    assign eoc_next = (warm || en_fall) ? 1'b0
        : eoc_set ? 1'b1
        : rd_res ? 1'b0 : eoc_reg;

    // mode register: software write first, then hardware clear of start
    always_comb
    begin
        mode_next = mode_reg;
        if (warm)
            mode_next = mode_s'(`ADC_RST_MODE);
        else if (en_fall)
            mode_next.start = 1'b0;
        else if (wr_mode)
        begin
            mode_next = mode_s'(wdata_i);
            mode_next.res3 = 1'b0;
            mode_next.res6 = 1'b0;
            mode_next.start = wdata_i[7] && enable_reg.converter_enable;
        end
        else if (stopping)
            mode_next.start = 1'b0;
    end

    // sequencer state transitions
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (start_rise)
                    state_next = ST_SAMPLE;
            ST_SAMPLE:
                if (smp_go)
                    state_next = ST_CONVERT;
            ST_CONVERT:
                if (done && !last_in_unit)
                    state_next = ST_SAMPLE;
                else if (restart)
                    state_next = ST_SAMPLE;
                else if (stopping)
                    state_next = ST_IDLE;
        endcase
        if (warm || en_fall)
            state_next = ST_IDLE;
    end

    // -------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------
    // timing reset clears the field bits; writes while enabled are trusted
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_reg <= enable_s'(`ADC_RST_ENABLE);
            mode_reg <= mode_s'(`ADC_RST_MODE);
            timing_reg <= timing_s'(`ADC_RST_TIMING);
            state_reg <= ST_IDLE;
            eoc_reg <= 1'b0;
        end
        else
        begin
            enable_reg <= enable_next;
            mode_reg <= mode_next;
            timing_reg <= warm ? timing_s'(`ADC_RST_TIMING)
                : wr_timing ? timing_s'(wdata_i[5:0]) : timing_reg;
            state_reg <= state_next;
            eoc_reg <= eoc_next;
        end
    end

    // divider and sampling counter; divider phase is free running,
    // so the first sampling tick may come up to one ratio early
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_reg <= 5'd0;
            smp_cnt_reg <= 7'd0;
        end
        else
        begin
            div_cnt_reg <= (tick || !enable_reg.converter_enable) ? 5'd0
                : div_cnt_reg + 5'd1;
            if (start_rise || (done && state_next == ST_SAMPLE))
                smp_cnt_reg <= delay_cyc;
            else if (state_reg == ST_SAMPLE && tick)
                smp_cnt_reg <= smp_cnt_reg - 7'd1;
        end
    end

    // channel, burst position and result pointer
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_reg <= 3'd0;
            burst_reg <= 2'd0;
            ptr_reg <= `ADC_RST_PTR;
        end
        else
        begin
            if (start_rise || restart)
            begin
                chan_reg <= mode_next.channel;
                burst_reg <= 2'd0;
            end
            else if (done && !last_in_unit)
            begin
                chan_reg <= chan_reg + 3'd1;
                burst_reg <= burst_reg + 2'd1;
            end
            // pointer is a status field, so a warm reset clears it too
            if (warm)
                ptr_reg <= `ADC_RST_PTR;
            else if (start_rise)
                ptr_reg <= `ADC_PTR_START;
            else if (done)
                ptr_reg <= wr_idx;
        end
    end

    // occupancy and overrun; a new result wins over a same-cycle read
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            full_reg <= 4'h0;
            ovf_reg <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (done && wr_idx == 2'(i))
                    full_reg[i] <= 1'b1;
                else if ((rd_res && res_idx == 2'(i)) || en_fall || warm)
                    full_reg[i] <= 1'b0;
            end
            if (warm || en_fall)
                ovf_reg <= 1'b0;
            else if (done && full_reg[wr_idx])
                ovf_reg <= 1'b1;
            else if (wr_status && wdata_i[`ADC_BIT_OVF])
                ovf_reg <= 1'b0;
        end
    end

    // results carry no reset so a warm reset keeps them; software may
    // preload them while the converter is disabled
    always_ff @(posedge ref_clk_i)
    begin
        if (done)
            result_mem[wr_idx] <= conv_data_i;
        else if (wr_res)
            result_mem[res_idx] <= wdata_i;
    end

    // -------------------------------------------------------------
    // read path and outputs
    // -------------------------------------------------------------
    wire [7:0] status_byte = {2'b00, ptr_reg, 1'b0, ovf_reg, busy, eoc_reg};
    wire [7:0] rd_mux = hit(addr_i, `ADC_OFF_ENABLE) ? {5'd0, enable_reg}
        : hit(addr_i, `ADC_OFF_STATUS) ? status_byte
        : hit(addr_i, `ADC_OFF_MODE) ? mode_reg
        : hit(addr_i, `ADC_OFF_TIMING) ? {2'b00, timing_reg}
        : res_hit ? result_mem[res_idx] : 8'h00;

    // every output is a flop; interrupt follows next-state values
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 8'h00;
            conv_start_reg <= 1'b0;
            abort_reg <= 1'b0;
            tick_reg <= 1'b0;
            ref_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rd_i ? rd_mux : 8'h00;
            conv_start_reg <= smp_go && !en_fall && !warm;
            abort_reg <= (en_fall || warm) && busy;
            tick_reg <= tick;
            ref_reg <= enable_next.int_ref && enable_next.converter_enable;
            irq_reg <= enable_next.irq_enable_bit && eoc_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign mux_channel_o = chan_reg;
    assign conv_start_o = conv_start_reg;
    assign conv_abort_o = abort_reg;
    assign conv_clk_tick_o = tick_reg;
    assign int_ref_on_o = ref_reg;
    assign irq_o = irq_reg;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_sample_go;
        smp_go && !en_fall && !warm;
    endsequence
    sequence s_launched;
        conv_start_o && state_reg == ST_CONVERT;
    endsequence

    a_irq_disabled_low: assert property (
        !enable_reg.irq_enable_bit |-> !irq_o)
        else $error("interrupt high while disabled");
    a_irq_on_eoc: assert property (
        enable_reg.irq_enable_bit && eoc_reg |-> irq_o)
        else $error("interrupt missing with end of conversion");
    a_irq_falls: assert property (
        $fell(eoc_reg) |-> !irq_o)
        else $error("interrupt stays after flag clear");
    a_mode_warm_clear: assert property (
        warm |=> mode_reg == mode_s'(`ADC_RST_MODE))
        else $error("mode not cleared by reset");
    a_reserved_zero: assert property (
        !mode_reg.res3 && !mode_reg.res6)
        else $error("reserved mode bit set");
    a_mux_first: assert property (
        start_rise && !warm
        |=> mux_channel_o == $past(wdata_i[2:0]) && state_reg == ST_SAMPLE)
        else $error("first channel not selected");
    a_scan_step: assert property (
        done && !last_in_unit && !en_fall && !warm
        |=> mux_channel_o == $past(chan_reg) + 3'd1 && state_reg == ST_SAMPLE)
        else $error("burst did not advance channel");
    a_single_clears: assert property (
        stopping && !mode_reg.continuous_bit && !wr_mode |=> !mode_reg.start)
        else $error("start not cleared after single run");
    a_continuous_bit_restart: assert property (
        restart && !en_fall && !warm && !wr_mode
        |=> mode_reg.start && state_reg == ST_SAMPLE)
        else $error("continuous mode did not restart");
    a_stop_idle: assert property (
        stopping |=> state_reg == ST_IDLE ##1 !conv_start_o)
        else $error("new conversion after stop");
    a_delay_launch: assert property (
        s_sample_go |=> s_launched)
        else $error("conversion not launched after delay");
    a_ptr_start: assert property (
        start_rise && !warm |=> ptr_reg == `ADC_PTR_START)
        else $error("pointer not preset on start");
    a_ptr_order: assert property (
        done && !warm |=> ptr_reg == $past(ptr_reg) + 2'd1)
        else $error("results out of order");
    a_eoc_read: assert property (
        rd_res && !eoc_set |=> !eoc_reg)
        else $error("flag not cleared by result read");
    a_disable_clears: assert property (
        en_fall |=> !eoc_reg && !ovf_reg && !mode_reg.start && !busy)
        else $error("disable left state behind");
    a_overrun_set: assert property (
        done && full_reg[wr_idx] && !warm && !en_fall |=> ovf_reg)
        else $error("overrun not flagged");
    a_div_two: assert property (
        tick && timing_reg.conv_clock_divide == 3'd1 && !en_fall && !warm
        |=> !tick ##1 (tick || !enable_reg.converter_enable))
        else $error("divide by two broken");
endmodule

// ---- adc_seq_cfg.svh ----
// register offsets, field positions and reset values of the converter control
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define ADC_OFF_ENABLE 8'h00
`define ADC_OFF_STATUS 8'h04
`define ADC_OFF_MODE 8'h08
`define ADC_OFF_TIMING 8'h0C
`define ADC_OFF_RESULT0 8'h10
`define ADC_BIT_OVF 2
`define ADC_RST_ENABLE 3'h0
`define ADC_RST_MODE 8'h00
`define ADC_RST_TIMING 6'h00
`define ADC_PTR_START 2'h3
`define ADC_RST_PTR 2'h0
`define ADC_CONV_CLOCK_DIVIDE_MAX 3'h5
`define ADC_DELAY_MAX 3'h6
`endif

// ---- adc_seq_pkg.sv ----
// types shared by the converter control logic
package adc_seq_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;
    typedef struct packed {
        logic irq_enable_bit;
        logic int_ref;
        logic converter_enable;
    } enable_s;
    typedef struct packed {
        logic start;
        logic res6;
        logic scan;
        logic continuous_bit;
        logic res3;
        logic [2:0] channel;
    } mode_s;
    typedef struct packed {
        logic [2:0] delay;
        logic [2:0] conv_clock_divide;
    } timing_s;
endpackage

// ---- adc_core_model.sv ----
// behavioural analog core that answers each hold-point pulse not cut short by an abort with a byte
`timescale 1ns/100ps
module adc_core_model
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic conv_start_i,
    input wire logic conv_abort_i,
    input wire logic [2:0] channel_i,
    input wire logic [7:0] lat_i,
    output logic conv_done_o,
    output logic [7:0] conv_data_o
);
    logic [7:0] cnt_reg;
    logic [7:0] last_reg;
    logic [2:0] ch_reg;
    logic run_reg;
    // ---------------------------------------------
    // conversion timer
    // ---------------------------------------------
    // an abort drops the pending result, as the real core would
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_reg <= 1'b0;
            cnt_reg <= 8'h00;
            ch_reg <= 3'h0;
            last_reg <= 8'h00;
        end
        else if (conv_abort_i)
            run_reg <= 1'b0;
        else if (conv_start_i)
        begin
            run_reg <= 1'b1;
            cnt_reg <= lat_i;
            ch_reg <= channel_i;
        end
        else if (run_reg && cnt_reg == 8'h00)
        begin
            run_reg <= 1'b0;
            last_reg <= conv_data_o;
        end
        else if (run_reg)
            cnt_reg <= cnt_reg - 8'h01;
    end
    // byte names its channel; between results the bus shows the inverse
    assign conv_done_o = run_reg && cnt_reg == 8'h00;
    assign conv_data_o = conv_done_o ? {5'h14, ch_reg} : ~last_reg;
endmodule

// ---- adc_sequencing_control_test.sv ----
// self-checking bench of the converter control against a core model
`timescale 1ns/100ps
`include "adc_seq_cfg.svh"
module adc_sequencing_control_test;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic warm_reset_pin_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic conv_done_i;
    logic [7:0] conv_data_i;
    logic [2:0] mux_channel_o;
    logic conv_start_o;
    logic conv_abort_o;
    logic conv_clk_tick_o;
    logic int_ref_on_o;
    logic irq_o;
    logic [7:0] lat = 8'h03;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    int starts = 0;
    int last_start = 0;
    int aborts = 0;
    adc_sequencing_control uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .warm_reset_pin_i(warm_reset_pin_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i), .mux_channel_o(mux_channel_o),
        .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
        .conv_clk_tick_o(conv_clk_tick_o), .int_ref_on_o(int_ref_on_o), .irq_o(irq_o));
    adc_core_model core (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .conv_start_i(conv_start_o), .conv_abort_i(conv_abort_o),
        .channel_i(mux_channel_o), .lat_i(lat), .conv_done_o(conv_done_i),
        .conv_data_o(conv_data_i));
    // ---------------------------------------------
    // clock and event counters
    // ---------------------------------------------
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (conv_start_o === 1'b1)
        begin
            starts <= starts + 1;
            last_start <= cyc;
        end
        if (conv_abort_o === 1'b1)
            aborts <= aborts + 1;
    end
    // ---------------------------------------------
    // bus and check helpers
    // ---------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    // polls status until end-of-conversion; a hang ends the run
    task automatic wait_eoc(output logic [7:0] s);
        for (int i = 0; i < 400; i++)
        begin
            rd(`ADC_OFF_STATUS, s);
            if (s[0] === 1'b1)
                return;
        end
        miscompares++;
        tally_and_finish();
    endtask
    task automatic wait_starts(input int n);
        for (int i = 0; i < 2000 && starts < n; i++)
            step();
        if (starts < n)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_reset;
        logic [7:0] v;
        // results have no cold reset value, so only control and status
        for (int a = 0; a < 4; a++)
        begin
            rd(8'(a * 4), v);
            check(v, 8'h00);
        end
        for (int n = 0; n < 4; n++)
        begin
            wr(8'(`ADC_OFF_RESULT0 + n * 4), 8'h00);
            rd(8'(`ADC_OFF_RESULT0 + n * 4), v);
            check(v, 8'h00);
        end
        wr(`ADC_OFF_MODE, 8'h48);
        rd(`ADC_OFF_MODE, v);
        check(v, 8'h00);
    endtask
    // each legal divide code, 0 to 5, gives its ratio between conversion clock ticks
    task automatic t_divider;
        int g;
        for (int c = 0; c < 6; c++)
        begin
            wr(`ADC_OFF_ENABLE, 8'h00);
            wr(`ADC_OFF_TIMING, 8'(c));
            wr(`ADC_OFF_ENABLE, 8'h01);
            for (int i = 0; i < 100 && conv_clk_tick_o !== 1'b1; i++)
                step();
            g = 0;
            do
            begin
                step();
                g++;
            end while (conv_clk_tick_o !== 1'b1 && g < 100);
            check(8'(g), 8'(1 << c));
        end
    endtask
    task automatic t_single;
        logic [7:0] v;
        int c0;
        int n0;
        wr(`ADC_OFF_ENABLE, 8'h00);
        wr(`ADC_OFF_TIMING, 8'h11);
        wr(`ADC_OFF_ENABLE, 8'h07);
        step();
        check({7'h00, int_ref_on_o}, 8'h01);
        c0 = cyc;
        n0 = starts;
        wr(`ADC_OFF_MODE, 8'h85);
        rd(`ADC_OFF_STATUS, v);
        check({7'h00, v[1]}, 8'h01);
        check({5'h00, mux_channel_o}, 8'h05);
        wait_eoc(v);
        check(8'(starts - n0), 8'h01);
        check({7'h00, (last_start - c0) inside {[5:15]}}, 8'h01);
        check({6'h00, v[5:4]}, 8'h00);
        check({7'h00, irq_o}, 8'h01);
        rd(`ADC_OFF_MODE, v);
        check(v, 8'h05);
        rd(`ADC_OFF_RESULT0, v);
        check(v, 8'hA5);
        rd(`ADC_OFF_STATUS, v);
        check({7'h00, v[0]}, 8'h00);
        check({7'h00, irq_o}, 8'h00);
    endtask
    // burst of four from channel 2 with the interrupt masked
    task automatic t_scan;
        logic [7:0] v;
        int n0;
        wr(`ADC_OFF_ENABLE, 8'h00);
        wr(`ADC_OFF_TIMING, 8'h00);
        wr(`ADC_OFF_ENABLE, 8'h01);
        n0 = starts;
        wr(`ADC_OFF_MODE, 8'hA2);
        wait_eoc(v);
        check({7'h00, irq_o}, 8'h00);
        check(8'(starts - n0), 8'h04);
        check({6'h00, v[5:4]}, 8'h03);
        rd(`ADC_OFF_MODE, v);
        check(v, 8'h22);
        for (int n = 0; n < 4; n++)
        begin
            rd(8'(`ADC_OFF_RESULT0 + n * 4), v);
            check(v, 8'(8'hA2 + n));
        end
    endtask
    task automatic t_continuous;
        logic [7:0] v;
        int n1;
        wr(`ADC_OFF_MODE, 8'h93);
        wait_starts(starts + 6);
        rd(`ADC_OFF_STATUS, v);
        check({7'h00, v[2]}, 8'h01);
        rd(`ADC_OFF_MODE, v);
        check(v, 8'h93);
        wr(`ADC_OFF_MODE, 8'h13);
        wait_eoc(v);
        n1 = starts;
        repeat (60) step();
        check(8'(starts - n1), 8'h00);
        wr(`ADC_OFF_STATUS, 8'h04);
        rd(`ADC_OFF_STATUS, v);
        check({7'h00, v[2]}, 8'h00);
    endtask
    // disable during a slow conversion aborts it and clears the flags
    task automatic t_abort;
        logic [7:0] v;
        int a0;
        lat <= 8'hC8;
        a0 = aborts;
        wr(`ADC_OFF_MODE, 8'h93);
        wait_starts(starts + 1);
        wr(`ADC_OFF_ENABLE, 8'h00);
        repeat (3) step();
        check(8'(aborts - a0), 8'h01);
        rd(`ADC_OFF_STATUS, v);
        check(v & 8'h07, 8'h00);
        rd(`ADC_OFF_MODE, v);
        check({7'h00, v[7]}, 8'h00);
        lat <= 8'h03;
    endtask
    task automatic t_warm;
        logic [7:0] v;
        logic [7:0] keep;
        rd(`ADC_OFF_RESULT0, keep);
        wr(`ADC_OFF_ENABLE, 8'h01);
        wr(`ADC_OFF_MODE, 8'h17);
        @(posedge ref_clk_i);
        warm_reset_pin_i <= 1'b1;
        @(posedge ref_clk_i);
        warm_reset_pin_i <= 1'b0;
        rd(`ADC_OFF_MODE, v);
        check(v, 8'h00);
        rd(`ADC_OFF_ENABLE, v);
        check(v, 8'h00);
        rd(`ADC_OFF_STATUS, v);
        check(v, 8'h00);
        rd(`ADC_OFF_RESULT0, v);
        check(v, keep);
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_reset();
        t_divider();
        t_single();
        t_scan();
        t_continuous();
        t_abort();
        t_warm();
        tally_and_finish();
    end
endmodule
